// ---- rtl/see_consts.svh ----
`ifndef SEE_CONSTS_SVH
`define SEE_CONSTS_SVH
// Instruction codes
`define SEE_OP_SET_LATCH   8'h06
`define SEE_OP_CLR_LATCH   8'h04
`define SEE_OP_STAT_RD     8'h05
`define SEE_OP_STAT_WR     8'h01
`define SEE_OP_MEM_RD      8'h03
`define SEE_OP_MEM_WR      8'h02
// Status bit positions
`define SEE_SR_LOCK        7
`define SEE_SR_GUARD_HI    3
`define SEE_SR_GUARD_LO    2
`define SEE_SR_LATCH       1
`define SEE_SR_BUSY        0
// Clock counts
`define SEE_CNT_OP         6'd8
`define SEE_CNT_STAT_WR    6'd16
`define SEE_CNT_ADDR_END   6'd24
// Protected region bases
`define SEE_GUARD_BASE_01  14'h3000
`define SEE_GUARD_BASE_10  14'h2000
`define SEE_ERASED         8'hFF
// Internal write time
`define SEE_WRITE_TIME_US  5000
`define SEE_CLK_MHZ        10
`define SEE_WRITE_CYCLES   (`SEE_WRITE_TIME_US * `SEE_CLK_MHZ)
`define SEE_MEM_WORDS      16384
`endif

// ---- rtl/see_pkg.sv ----
package see_pkg;
   typedef enum logic [2:0] {
      SEE_OPCODE  = 3'b000,
      SEE_ADDR    = 3'b001,
      SEE_MEM_RD  = 3'b011,
      SEE_MEM_WR  = 3'b010,
      SEE_STAT_RD = 3'b110,
      SEE_STAT_WR = 3'b111,
      SEE_IGNORE  = 3'b101,
      SEE_WAIT_CS = 3'b100
   } see_phase_t;

   typedef struct packed {
      logic cs_n;
      logic sck;
      logic din;
      logic wp_n;
      logic hold_n;
   } see_pins_t;
endpackage

// ---- rtl/see_core.sv ----
`timescale 1ns/1ps
`include "see_consts.svh"
// Behaviour
// - Instruction starts after chip select falls; one byte, MSB first.
// - 06h sets write latch, 04h clears it; no address or data.
// - 05h reads status bits 7..0; 01h writes one status byte.
// - 03h reads, 02h writes memory; 16-bit address, top two ignored.
// - Continued read clocking outputs following addresses in turn.
// - Undefined code ignores rest of transfer until chip select rises.
// - Status: lock b7, guards b3/b2, latch b1, busy b0.
// - Bits 6..4 read zero; status write changes only lock and guards.
// - Lock set with protect pin low blocks status writes.
// - Guard bits cleared by reset, define protected area, writable unless hardware guard.
// - Only set-latch command sets latch; latch zero refuses writes.
// - Latch clears at reset, clear command, and write completion.
// - Busy bit reads one only during internal write.
// - Set-latch executes only with exactly eight clocks.
// - Clear-latch executes only with exactly eight clocks.
// - Lock and guards keep old values until write cycle completes.
// - Status read works anytime, repeats byte with live latch and busy.
// - Hold tristates output and ignores input and clock.
// - Memory starts FFh; lock and guards start zero.
// - Instruction, address and data sampled on clock rising edge.
// - Output data changes on clock falling edge.
// - Guards 01 protect 3000h up, 10 from 2000h, 11 everything.
module see_core
   import see_pkg::*;
#(
   parameter int WRITE_CYCLES = `SEE_WRITE_CYCLES
)(
   // System
   input  wire logic      clk_sys,
   input  wire logic      rstn,
   // Serial pins
   input  wire see_pins_t pins,
   output logic           dout,
   output logic           dout_oe,
   // Status view
   output logic [7:0]     status
);
   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   see_pins_t sync1_reg, sync2_reg, prev_reg;
   logic      held, hold_reg;
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         sync1_reg <= 5'b1_0011;
         sync2_reg <= 5'b1_0011;
         prev_reg  <= 5'b1_0011;
         hold_reg  <= 1'b0;
      end else begin
         sync1_reg <= pins;
         sync2_reg <= sync1_reg;
         prev_reg  <= sync2_reg;
         hold_reg  <= held;
      end
   end
   // Hold enters and leaves only while the clock is low
   assign held = sync2_reg.sck ? hold_reg : !sync2_reg.hold_n;
   logic sel, rise, fall, cs_rise, cs_fall;
   assign sel     = !sync2_reg.cs_n;
   assign rise    = sel && sync2_reg.sck && !prev_reg.sck && !held;
   assign fall    = sel && !sync2_reg.sck && prev_reg.sck && !held;
   assign cs_rise = sync2_reg.cs_n && !prev_reg.cs_n;
   assign cs_fall = !sync2_reg.cs_n && prev_reg.cs_n;

   function automatic logic guarded(input logic [1:0] g, input logic [13:0] a);
      unique case (g)
         2'b00: guarded = 1'b0;
         2'b01: guarded = (a >= `SEE_GUARD_BASE_01);
         2'b10: guarded = (a >= `SEE_GUARD_BASE_10);
         2'b11: guarded = 1'b1;
      endcase
   endfunction

   // ------------------------------------------------------------
   // Memory array
   // ------------------------------------------------------------
   // Erased pattern from power-up; no reset branch for the whole array
   logic [7:0] mem [`SEE_MEM_WORDS] = '{default: `SEE_ERASED};

   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------
   see_phase_t  ph_reg, ph_next;
   logic [5:0]  cnt_reg, cnt_next;
   logic [7:0]  sh_reg, sh_next;
   logic [7:0]  op_reg, op_next;
   logic [13:0] adr_reg, adr_next;
   logic [7:0]  out_reg, out_next;
   logic        dout_reg, dout_next;
   logic        oe_reg, oe_next;
   logic        lock_reg, lock_next;
   logic [1:0]  guard_reg, guard_next;
   logic        latch_reg, latch_next;
   logic        busy_reg, busy_next;
   logic [31:0] tmr_reg, tmr_next;
   logic        pend_stat_reg, pend_stat_next;
   logic [7:0]  new_stat_reg, new_stat_next;
   logic [7:0]  wbuf [64];
   logic [63:0] wval_reg, wval_next;
   logic        pend_mem_reg, pend_mem_next;
   logic        mem_we;
   logic [7:0]  mem_wd;
   logic [5:0]  mem_wi;
   logic        hw_guard;
   logic [7:0]  sh_in;
   logic [7:0]  live_stat;

   assign hw_guard  = lock_reg && !sync2_reg.wp_n;
   assign sh_in     = {sh_reg[6:0], sync2_reg.din};
   assign live_stat = {lock_reg, 3'b000, guard_reg, latch_reg, busy_reg};
   assign status    = live_stat;
   assign dout      = dout_reg;
   assign dout_oe   = oe_reg && !held;

   always_comb begin
      ph_next        = ph_reg;
      cnt_next       = cnt_reg;
      sh_next        = sh_reg;
      op_next        = op_reg;
      adr_next       = adr_reg;
      out_next       = out_reg;
      dout_next      = dout_reg;
      oe_next        = oe_reg;
      lock_next      = lock_reg;
      guard_next     = guard_reg;
      latch_next     = latch_reg;
      busy_next      = busy_reg;
      tmr_next       = tmr_reg;
      pend_stat_next = pend_stat_reg;
      new_stat_next  = new_stat_reg;
      wval_next      = wval_reg;
      pend_mem_next  = pend_mem_reg;
      mem_we         = 1'b0;
      mem_wd         = sh_in;
      mem_wi         = adr_reg[5:0];
      // Internal write cycle timer
      if (busy_reg) begin
         if (tmr_reg == 32'h0000_0000) begin
            busy_next  = 1'b0;
            latch_next = 1'b0;
            if (pend_stat_reg) begin
               lock_next  = new_stat_reg[`SEE_SR_LOCK];
               guard_next = new_stat_reg[`SEE_SR_GUARD_HI:`SEE_SR_GUARD_LO];
            end
            pend_stat_next = 1'b0;
            pend_mem_next  = 1'b0;
         end else begin
            tmr_next = tmr_reg - 32'h0000_0001;
         end
      end
      if (cs_fall) begin
         ph_next  = SEE_OPCODE;
         cnt_next = 6'd0;
         oe_next  = 1'b1;
      end else if (cs_rise) begin
         oe_next  = 1'b0;
         ph_next  = SEE_OPCODE;
         cnt_next = 6'd0;
         if (cnt_reg == `SEE_CNT_OP && !busy_reg) begin
            if (op_reg == `SEE_OP_SET_LATCH) latch_next = 1'b1;
            if (op_reg == `SEE_OP_CLR_LATCH) latch_next = 1'b0;
         end
         if (op_reg == `SEE_OP_STAT_WR && cnt_reg == `SEE_CNT_STAT_WR
             && latch_reg && !hw_guard && !busy_reg) begin
            new_stat_next  = sh_reg;
            pend_stat_next = 1'b1;
            busy_next      = 1'b1;
            tmr_next       = 32'(WRITE_CYCLES);
         end
         if (op_reg == `SEE_OP_MEM_WR && cnt_reg > `SEE_CNT_ADDR_END
             && cnt_reg[2:0] == 3'd0 && latch_reg && !busy_reg
             && !guarded(guard_reg, adr_reg)) begin
            pend_mem_next = 1'b1;
            busy_next     = 1'b1;
            tmr_next      = 32'(WRITE_CYCLES);
         end
      end else if (rise) begin
         sh_next = sh_in;
         if (cnt_reg != 6'd63) cnt_next = cnt_reg + 6'd1;
         unique case (ph_reg)
            SEE_OPCODE: if (cnt_reg == 6'd7) begin
               op_next = sh_in;
               // A status read during a page write must not drop the page
               if (!busy_reg) wval_next = 64'h0;
               unique case (sh_in)
                  `SEE_OP_SET_LATCH, `SEE_OP_CLR_LATCH: ph_next = SEE_WAIT_CS;
                  `SEE_OP_STAT_RD: begin
                     ph_next  = SEE_STAT_RD;
                     out_next = live_stat;
                  end
                  `SEE_OP_STAT_WR: ph_next = SEE_STAT_WR;
                  `SEE_OP_MEM_RD, `SEE_OP_MEM_WR: begin
                     // Array busy: keep the page address and buffer intact
                     ph_next = busy_reg ? SEE_IGNORE : SEE_ADDR;
                     if (busy_reg) oe_next = 1'b0;
                  end
                  default: begin
                     ph_next = SEE_IGNORE;
                     oe_next = 1'b0;
                  end
               endcase
            end
            SEE_ADDR: begin
               // Two top address bits are dropped
               if (cnt_reg == 6'd15) adr_next = {sh_in[5:0], adr_reg[7:0]};
               if (cnt_reg == 6'd23) begin
                  adr_next = {adr_reg[13:8], sh_in};
                  if (op_reg == `SEE_OP_MEM_RD) begin
                     ph_next  = SEE_MEM_RD;
                     out_next = mem[{adr_reg[13:8], sh_in}];
                  end else begin
                     ph_next = SEE_MEM_WR;
                  end
               end
            end
            SEE_MEM_WR: if (cnt_reg[2:0] == 3'd7 && !busy_reg) begin
               mem_we = 1'b1;
               mem_wi = adr_reg[5:0];
               wval_next = wval_reg | (64'h1 << adr_reg[5:0]);
               adr_next = {adr_reg[13:6], adr_reg[5:0] + 6'd1};
            end
            SEE_MEM_RD: if (cnt_reg[2:0] == 3'd7) begin
               adr_next = adr_reg + 14'd1;
               out_next = mem[adr_reg + 14'd1];
            end
            SEE_STAT_RD: if (cnt_reg[2:0] == 3'd7) out_next = live_stat;
            default: ;
         endcase
      end else if (fall) begin
         if (ph_reg == SEE_STAT_RD || ph_reg == SEE_MEM_RD) begin
            dout_next = out_reg[7];
            out_next  = {out_reg[6:0], out_reg[7]};
         end
      end
      if (!sel) oe_next = 1'b0;
   end

   always_ff @(posedge clk_sys) begin
      if (mem_we) begin
         wbuf[mem_wi] <= mem_wd;
      end
      if (busy_reg && pend_mem_reg && tmr_reg == 32'h0000_0000) begin
         for (int i = 0; i < 64; i++)
            if (wval_reg[i]) mem[{adr_reg[13:6], 6'(i)}] <= wbuf[i];
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         ph_reg        <= SEE_OPCODE;
         cnt_reg       <= 6'd0;
         sh_reg        <= 8'h00;
         op_reg        <= 8'h00;
         adr_reg       <= 14'h0000;
         out_reg       <= 8'h00;
         dout_reg      <= 1'b0;
         oe_reg        <= 1'b0;
         lock_reg      <= 1'b0;
         guard_reg     <= 2'b00;
         latch_reg     <= 1'b0;
         busy_reg      <= 1'b0;
         tmr_reg       <= 32'h0000_0000;
         pend_stat_reg <= 1'b0;
         new_stat_reg  <= 8'h00;
         wval_reg      <= 64'h0;
         pend_mem_reg  <= 1'b0;
      end else begin
         ph_reg        <= ph_next;
         cnt_reg       <= cnt_next;
         sh_reg        <= sh_next;
         op_reg        <= op_next;
         adr_reg       <= adr_next;
         out_reg       <= out_next;
         dout_reg      <= dout_next;
         oe_reg        <= oe_next;
         lock_reg      <= lock_next;
         guard_reg     <= guard_next;
         latch_reg     <= latch_next;
         busy_reg      <= busy_next;
         tmr_reg       <= tmr_next;
         pend_stat_reg <= pend_stat_next;
         new_stat_reg  <= new_stat_next;
         wval_reg      <= wval_next;
         pend_mem_reg  <= pend_mem_next;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   a_zero_bits: assert property (@(posedge clk_sys) disable iff (!rstn)
      status[6:4] == 3'b000) else $error("Status bits 6..4 not zero");
   a_lock_hold: assert property (@(posedge clk_sys) disable iff (!rstn)
      busy_reg && tmr_reg != 0 |=> $stable(lock_reg) && $stable(guard_reg))
      else $error("Lock changed mid cycle");
   a_busy_end: assert property (@(posedge clk_sys) disable iff (!rstn)
      $fell(busy_reg) |-> !latch_reg) else $error("Latch survived write");
   a_hw_guard: assert property (@(posedge clk_sys) disable iff (!rstn)
      hw_guard && !busy_reg |=> !$rose(busy_reg) || pend_mem_reg)
      else $error("Status write under hardware guard");
   a_latch_set: assert property (@(posedge clk_sys) disable iff (!rstn)
      $rose(latch_reg) |-> $past(op_reg) == `SEE_OP_SET_LATCH)
      else $error("Latch set by other command");
   a_oe_desel: assert property (@(posedge clk_sys) disable iff (!rstn)
      !sel |=> !dout_oe) else $error("Output driven while deselected");
   a_ignore_quiet: assert property (@(posedge clk_sys) disable iff (!rstn)
      ph_reg == SEE_IGNORE && !cs_fall |=> !oe_reg) else $error("Drive after bad code");
   a_busy_start: assert property (@(posedge clk_sys) disable iff (!rstn)
      $rose(busy_reg) |-> $past(cs_rise) && $past(latch_reg))
      else $error("Write began without latch");
   c_stat_wr: cover property (@(posedge clk_sys) $fell(pend_stat_reg));
   c_mem_wr:  cover property (@(posedge clk_sys) $fell(pend_mem_reg));
   c_stat_rd: cover property (@(posedge clk_sys) ph_reg == SEE_STAT_RD && busy_reg);
endmodule

// ---- test/see_host.sv ----
`timescale 1ns/1ps
module see_host
   import see_pkg::*;
(
   // System
   input  wire logic clk_sys,
   // Serial pins
   output see_pins_t pins,
   input  wire logic dout,
   input  wire logic dout_oe
);
   // ---------------------------------------------
   // Idle levels
   // ---------------------------------------------
   // Clock stands low between frames; hold is never used
   initial begin
      pins = '{cs_n: 1'b1, sck: 1'b0, din: 1'b1, wp_n: 1'b1, hold_n: 1'b1};
   end

   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk_sys);
   endtask

   task automatic set_wp(input logic v);
      @(posedge clk_sys);
      pins.wp_n <= v;
   endtask

   // ---------------------------------------------
   // One select period, n clocks, MSB first
   // ---------------------------------------------
   task automatic frame(input logic [39:0] tx, input int n, output logic [39:0] rx);
      rx = '0;
      @(posedge clk_sys);
      pins.cs_n <= 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         @(posedge clk_sys);
         pins.din <= tx[i];
         repeat (3) @(posedge clk_sys);
         pins.sck <= 1'b1;
         repeat (2) @(posedge clk_sys);
         // Undriven output is not taken as data
         rx[i] = (dout_oe === 1'b1) ? dout : 1'bz;
         repeat (2) @(posedge clk_sys);
         pins.sck <= 1'b0;
      end
      repeat (4) @(posedge clk_sys);
      pins.cs_n <= 1'b1;
      // Released line must not keep showing the last bit
      pins.din  <= ~pins.din;
      repeat (4) @(posedge clk_sys);
   endtask
endmodule

// ---- test/test_serial_eeprom_cmd_status.sv ----
`timescale 1ns/1ps
module test_serial_eeprom_cmd_status
   import see_pkg::*;
;
   localparam int WCYC = 400;

   logic        clk_sys;
   logic        rstn;
   see_pins_t   pins;
   logic        dout;
   logic        dout_oe;
   logic [7:0]  status;
   logic [39:0] rx;
   int          err_count;
   int          total_checks;

   // ---------------------------------------------
   // Design and host
   // ---------------------------------------------
   // Write time long enough to read status while busy
   see_core #(.WRITE_CYCLES(WCYC)) see_core_i (
      .clk_sys (clk_sys),
      .rstn    (rstn),
      .pins    (pins),
      .dout    (dout),
      .dout_oe (dout_oe),
      .status  (status)
   );

   see_host see_host_i (
      .clk_sys (clk_sys),
      .pins    (pins),
      .dout    (dout),
      .dout_oe (dout_oe)
   );

   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end

   // ---------------------------------------------
   // Helpers
   // ---------------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic stat(input logic [7:0] exp);
      check({8'h00, status}, {8'h00, exp});
   endtask

   task automatic cmd(input logic [39:0] tx, input int n);
      see_host_i.frame(tx, n, rx);
      see_host_i.wait_clk(6);
   endtask

   task automatic test_done(input string name);
      $display("Test %s done, mismatches so far %0d", name, err_count);
   endtask

   task automatic tally_and_finish();
      $display("Checks %0d, mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // ---------------------------------------------
   // Tests
   // ---------------------------------------------
   initial begin
      err_count    = 0;
      total_checks = 0;
      rstn         = 1'b0;
      repeat (16) @(posedge clk_sys);
      rstn <= 1'b1;
      repeat (2) @(posedge clk_sys);
      stat(8'h00);
      test_done("reset");
      cmd(40'h00_0000_000C, 9);
      stat(8'h00);
      cmd(40'h00_0000_0006, 8);
      stat(8'h02);
      cmd(40'h00_0000_0002, 7);
      stat(8'h02);
      cmd(40'h00_0000_0004, 8);
      stat(8'h00);
      test_done("latch counts");
      cmd(40'h00_0000_018C, 16);
      stat(8'h00);
      cmd(40'h00_0000_AA06, 16);
      stat(8'h00);
      test_done("refusals");
      cmd(40'h00_0000_0006, 8);
      cmd(40'h00_0000_01FF, 16);
      stat(8'h03);
      see_host_i.frame(40'h00_0005_0000, 24, rx);
      check(rx[15:0], 16'h0303);
      see_host_i.wait_clk(WCYC);
      stat(8'h8C);
      test_done("status write");
      see_host_i.set_wp(1'b0);
      cmd(40'h00_0000_0006, 8);
      cmd(40'h00_0000_0100, 16);
      stat(8'h8E);
      see_host_i.set_wp(1'b1);
      cmd(40'h00_0000_0200, 17);
      stat(8'h8E);
      cmd(40'h00_0000_0100, 16);
      stat(8'h8F);
      see_host_i.wait_clk(WCYC);
      stat(8'h00);
      test_done("protection");
      see_host_i.frame(40'h03_C000_0000, 40, rx);
      check(rx[15:0], 16'hFFFF);
      test_done("memory read");
      cmd(40'h00_0000_0006, 8);
      cmd(40'h02_D005_A55A, 40);
      stat(8'h03);
      see_host_i.wait_clk(WCYC);
      stat(8'h00);
      see_host_i.frame(40'h03_1005_0000, 40, rx);
      check(rx[15:0], 16'hA55A);
      test_done("memory write");
      tally_and_finish();
   end

   // Whole sequence needs well under half of this
   initial begin
      repeat (20000) @(posedge clk_sys);
      err_count++;
      $display("ERROR %0t: watchdog expired", $time);
      tally_and_finish();
   end
endmodule
